// >>> src/ebg_arbiter.sv
// External bus request and grant arbiter of the processor core.
// Assumes all pins synchronous to core_clk_in; core reports its access state.
`timescale 1ns/100ps
module ebg_arbiter (
  // Clock and reset
  input  wire logic                       core_clk_in,
  input  wire logic                       sys_rst_in,
  // Reset and mode pins
  input  wire logic                       proc_reset_n_in,
  input  wire logic [ebg_pkg::MODE_W-1:0] mode_pins_in,
  output logic                            core_reset_out,
  output logic [ebg_pkg::MODE_W-1:0]      mem_mode_out,
  // Request and grant pins
  input  wire logic                       bus_request_n_in,
  output logic                            grant_out_n_out,
  output logic                            grant_out_n_oe_out,
  output logic                            grant_hang_n_out,
  // Emulator pins
  input  wire logic                       emulator_takeover_in,
  input  wire logic                       emu_request_n_in,
  input  wire logic                       emu_reset_n_in,
  output logic                            emu_grant_n_out,
  // Core side
  input  wire ebg_pkg::ebg_core_t         core_in,
  input  wire ebg_pkg::ebg_mem_t          mem_in,
  output logic                            core_halt_out,
  output logic                            ext_stall_out,
  output logic [ebg_pkg::DATA_W-1:0]      rdata_out,
  // Memory bus pins
  output logic [ebg_pkg::ADDR_W-1:0]      addr_out,
  output logic                            addr_oe_out,
  input  wire logic [ebg_pkg::DATA_W-1:0] data_in,
  output logic [ebg_pkg::DATA_W-1:0]      data_out,
  output logic                            data_oe_out,
  output ebg_pkg::ebg_strobe_t            strobe_out,
  output logic                            strobe_oe_out
);
  import ebg_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ebg_state_t        state;
    logic              req;
    logic              grant_n;
    logic              emu_grant_n;
    logic              drive;
    logic [DATA_W-1:0] rdata;
  } ebg_st_t;

  ebg_st_t st_r;
  ebg_st_t st_nxt;

  logic chip_rst;
  logic req_n_sel;
  logic granted;
  logic blocked;

  // ----------------------------------------------------------------
  // Pin selection and mode latch
  // ----------------------------------------------------------------
  ebg_emu_sel u_sel (
    .core_clk_in          (core_clk_in),
    .sys_rst_in           (sys_rst_in),
    .emulator_takeover_in (emulator_takeover_in),
    .proc_reset_n_in      (proc_reset_n_in),
    .emu_reset_n_in       (emu_reset_n_in),
    .proc_request_n_in    (bus_request_n_in),
    .emu_request_n_in     (emu_request_n_in),
    .mode_pins_in         (mode_pins_in),
    .chip_reset_out       (chip_rst),
    .request_n_out        (req_n_sel),
    .mem_mode_out         (mem_mode_out)
  );

  assign core_reset_out = chip_rst;

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  // Chip reset only reaches the core; the handshake keeps running through it
  always_comb begin
    st_nxt     = st_r;
    st_nxt.req = !req_n_sel;
    case (st_r.state)
      EBG_IDLE: begin
        if (st_r.req && core_in.ext_busy) begin
          st_nxt.state = EBG_WAIT;
        end else if (st_r.req) begin
          st_nxt.state = EBG_GRANT;
        end
      end
      EBG_WAIT: begin
        if (!st_r.req) begin
          st_nxt.state = EBG_IDLE;
        end else if (!core_in.ext_busy) begin
          st_nxt.state = EBG_GRANT;
        end
      end
      EBG_GRANT: begin
        if (!st_r.req) begin
          st_nxt.state = EBG_IDLE;
        end
      end
      default: begin
        st_nxt.state = EBG_IDLE;
      end
    endcase
    // Pin levels follow the next state so they come straight from flops
    st_nxt.drive       = (st_nxt.state != EBG_GRANT);
    st_nxt.grant_n     = (st_nxt.state != EBG_GRANT) || emulator_takeover_in;
    st_nxt.emu_grant_n = (st_nxt.state != EBG_GRANT) || !emulator_takeover_in;
    if (!core_in.ext_busy || st_r.drive) begin
      st_nxt.rdata = data_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      st_r <= '{state: EBG_IDLE, req: !REQ_OFF, grant_n: GRANT_OFF,
                emu_grant_n: GRANT_OFF, drive: 1'b1, rdata: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Core stall and hang
  // ----------------------------------------------------------------
  assign granted = (st_r.state == EBG_GRANT);
  // Go mode runs on until the core needs the bus it gave away
  assign blocked = granted && (!core_in.go_mode || core_in.ext_req);

  assign core_halt_out    = blocked;
  assign ext_stall_out    = granted && core_in.ext_req;
  assign grant_hang_n_out = !(blocked && core_in.ready);
  assign rdata_out        = st_r.rdata;

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  assign grant_out_n_out    = st_r.grant_n;
  assign grant_out_n_oe_out = !emulator_takeover_in;
  assign emu_grant_n_out    = st_r.emu_grant_n;
  assign addr_out           = mem_in.addr;
  assign data_out           = mem_in.wdata;
  assign strobe_out         = mem_in.strobe;
  assign addr_oe_out        = st_r.drive;
  assign strobe_oe_out      = st_r.drive;
  assign data_oe_out        = st_r.drive && mem_in.wdrive;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  property p_tristate;
    granted |-> !addr_oe_out && !strobe_oe_out && !data_oe_out;
  endproperty
  a_tristate: assert property (p_tristate) else $error("bus driven while granted");

  property p_grant_next;
    st_r.state == EBG_IDLE && st_r.req && !core_in.ext_busy && !emulator_takeover_in
      |=> !grant_out_n_out && (core_in.go_mode || core_halt_out);
  endproperty
  a_grant_next: assert property (p_grant_next) else $error("grant late after request");

  property p_go_mode;
    granted && core_in.go_mode && !core_in.ext_req |-> !core_halt_out && grant_hang_n_out;
  endproperty
  a_go_mode: assert property (p_go_mode) else $error("go mode halted without access");

  property p_wait_access;
    st_r.state == EBG_IDLE && st_r.req && core_in.ext_busy |=> !granted ##0 addr_oe_out;
  endproperty
  a_wait_access: assert property (p_wait_access) else $error("granted during access");

  property p_between;
    st_r.state == EBG_WAIT && st_r.req && !core_in.ext_busy |=> granted;
  endproperty
  a_between: assert property (p_between) else $error("no grant between accesses");

  property p_release;
    granted && !st_r.req |=> !granted && addr_oe_out && strobe_oe_out && !core_halt_out;
  endproperty
  a_release: assert property (p_release) else $error("grant kept after withdraw");

  property p_reset_serviced;
    chip_rst && st_r.state == EBG_IDLE && st_r.req && !core_in.ext_busy |=> granted;
  endproperty
  a_reset_serviced: assert property (p_reset_serviced) else $error("no grant in reset");

  property p_hang;
    granted && core_in.ready && core_in.ext_req |-> !grant_hang_n_out && ext_stall_out;
  endproperty
  a_hang: assert property (p_hang) else $error("hang not shown while blocked");

  property p_after_release;
    granted ##1 !granted |-> grant_out_n_out && emu_grant_n_out && grant_hang_n_out
      && !ext_stall_out;
  endproperty
  a_after_release: assert property (p_after_release) else $error("release incomplete");

  property p_emu_pins;
    emulator_takeover_in |-> !grant_out_n_oe_out ##1 (granted == !emu_grant_n_out);
  endproperty
  a_emu_pins: assert property (p_emu_pins) else $error("emulator grant wrong");

  property p_sample;
    !req_n_sel ##1 !req_n_sel |-> st_r.req;
  endproperty
  a_sample: assert property (p_sample) else $error("request not sampled");

  c_grant:   cover property (st_r.state == EBG_IDLE ##1 granted ##[1:8] !granted);
  c_wait:    cover property (st_r.state == EBG_WAIT ##1 granted);
  c_go_hang: cover property (granted && core_in.go_mode ##1 !grant_hang_n_out);
  c_emu:     cover property (emulator_takeover_in && !emu_grant_n_out);

endmodule

// >>> pkg/ebg_pkg.sv
// Constants, types and carriers shared by the external bus grant block.
// Assumes one 250 MHz clock and pins taken as synchronous to it.
//
// How it works
// - Idle request three-states buses and strobes
// - Grant and halt the cycle after
// - Go mode halts only on external access
// - Access in flight delays the grant
// - Grant may fall between two accesses
// - Request withdrawn: release grant, resume
// - Handshake serviced during reset and boot
// - Hang flag when core ready but blocked by grant
// - On release drop grant and hang, resume access in the same cycle
// - Emulator pins replace normal; grant three-stated
// - Emulator reset re-latches memory mode pins
package ebg_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 14;
  localparam int DATA_W = 24;
  localparam int MODE_W = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [MODE_W-1:0] MODE_RST  = 3'h0;
  localparam logic              GRANT_OFF = 1'b1;
  localparam logic              REQ_OFF   = 1'b1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EBG_IDLE  = 2'b00,
    EBG_WAIT  = 2'b01,
    EBG_GRANT = 2'b10
  } ebg_state_t;

  // Memory strobes, all active low
  typedef struct packed {
    logic program_select_n;
    logic data_select_n;
    logic byte_select_n;
    logic composite_select_n;
    logic io_select_n;
    logic rd_n;
    logic wr_n;
  } ebg_strobe_t;

  // Core pipeline status toward the arbiter
  typedef struct packed {
    logic ready;
    logic ext_req;
    logic ext_busy;
    logic go_mode;
  } ebg_core_t;

  // Memory bus as driven by the core
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wdrive;
    ebg_strobe_t       strobe;
  } ebg_mem_t;

endpackage

// >>> src/ebg_emu_sel.sv
// Emulator pin selection and memory mode latch.
// Assumes emulator and normal pins are synchronous to the core clock.
`timescale 1ns/100ps
module ebg_emu_sel (
  // Clock and reset
  input  wire logic                       core_clk_in,
  input  wire logic                       sys_rst_in,
  // Pins
  input  wire logic                       emulator_takeover_in,
  input  wire logic                       proc_reset_n_in,
  input  wire logic                       emu_reset_n_in,
  input  wire logic                       proc_request_n_in,
  input  wire logic                       emu_request_n_in,
  input  wire logic [ebg_pkg::MODE_W-1:0] mode_pins_in,
  // Selected
  output logic                            chip_reset_out,
  output logic                            request_n_out,
  output logic [ebg_pkg::MODE_W-1:0]      mem_mode_out
);
  import ebg_pkg::*;

  typedef struct packed {
    logic              rst;
    logic [MODE_W-1:0] mode;
  } ebg_sel_st_t;

  ebg_sel_st_t st_r;
  ebg_sel_st_t st_nxt;
  logic        rst_sel;

  // ----------------------------------------------------------------
  // Pin selection
  // ----------------------------------------------------------------
  assign rst_sel       = emulator_takeover_in ? !emu_reset_n_in : !proc_reset_n_in;
  assign request_n_out = emulator_takeover_in ? emu_request_n_in : proc_request_n_in;

  // Mode follows the pins while the selected reset pin is held, freezes on release
  always_comb begin
    st_nxt     = st_r;
    st_nxt.rst = rst_sel;
    if (rst_sel) begin
      st_nxt.mode = mode_pins_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      st_r <= '{rst: 1'b1, mode: MODE_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign chip_reset_out = st_r.rst;
  assign mem_mode_out   = st_r.mode;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_mode_latch;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      emulator_takeover_in && !emu_reset_n_in |=> mem_mode_out == $past(mode_pins_in);
  endproperty
  a_mode_latch: assert property (p_mode_latch) else $error("mode not latched on reset");

  property p_mode_hold;
    @(posedge core_clk_in) disable iff (sys_rst_in)
      !chip_reset_out && !rst_sel |=> $stable(mem_mode_out);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode moved outside reset");

endmodule

// >>> verification/ebg_master_model.sv
// External bus master that borrows the memory bus from the arbiter.
// Assumes the grant is active low and is sampled on the core clock.
`timescale 1ns/100ps
module ebg_master_model (
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       sys_rst_in,
  // Bench control
  input  wire logic       start_in,
  input  wire logic [7:0] hold_in,
  output logic            granted_out,
  output logic [7:0]      lat_out,
  // Pins
  input  wire logic       grant_n_in,
  output logic            request_n_out
);
  import ebg_pkg::*;
  logic       busy_r;
  logic [7:0] cnt_r;

  // ------------------------------------------------------------
  // Request, use while granted, withdraw
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      request_n_out <= REQ_OFF;
      busy_r        <= 1'b0;
      granted_out   <= 1'b0;
      cnt_r         <= 8'h00;
      lat_out       <= 8'h00;
    end else if (start_in && !busy_r) begin
      request_n_out <= 1'b0;
      busy_r        <= 1'b1;
      cnt_r         <= 8'h00;
      granted_out   <= 1'b0;
    end else if (busy_r && !granted_out) begin
      // Bus untouched until grant seen low
      if (!grant_n_in) begin
        granted_out <= 1'b1;
        lat_out     <= cnt_r + 8'h01;
        cnt_r       <= 8'h00;
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end else if (busy_r) begin
      if (cnt_r == hold_in) begin
        request_n_out <= REQ_OFF;
        busy_r        <= 1'b0;
        granted_out   <= 1'b0;
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end
endmodule

// >>> verification/external_bus_request_grant_test.sv
// Self-checking bench for the bus request and grant arbiter.
// Assumes ebg_pkg and the master model are compiled before it.
`timescale 1ns/100ps
module external_bus_request_grant_test;
  import ebg_pkg::*;
  typedef struct packed {
    logic go; logic rdy; logic xreq; logic chk; logic halt; logic hang_n;
  } ebg_row_t;
  // go rdy xreq chk halt hang_n
  localparam ebg_row_t ROWS [4] = '{6'b010110, 6'b000111, 6'b110101, 6'b111110};

  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              prst_n = 1'b1, etake = 1'b0, ereq_n = 1'b1, erst_n = 1'b1;
  logic [MODE_W-1:0] mode = 3'h0;
  ebg_core_t         core = '0;
  ebg_mem_t          mem;
  logic              start = 1'b0, granted, req_n;
  logic [7:0]        lat;
  logic              rst_o, gnt_n, gnt_oe, hang_n, egnt_n, halt, a_oe, d_oe, s_oe;
  logic              stall;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dout, rdat;
  ebg_strobe_t       strb;
  logic [MODE_W-1:0] mmode;
  int                failures = 0, n_tests = 0, cycles = 0;

  always #2 clk = ~clk;

  ebg_arbiter u_dut (
    .core_clk_in(clk), .sys_rst_in(rst), .proc_reset_n_in(prst_n), .mode_pins_in(mode),
    .core_reset_out(rst_o), .mem_mode_out(mmode), .bus_request_n_in(req_n),
    .grant_out_n_out(gnt_n), .grant_out_n_oe_out(gnt_oe), .grant_hang_n_out(hang_n),
    .emulator_takeover_in(etake), .emu_request_n_in(ereq_n), .emu_reset_n_in(erst_n),
    .emu_grant_n_out(egnt_n), .core_in(core), .mem_in(mem), .core_halt_out(halt),
    .ext_stall_out(stall), .rdata_out(rdat), .addr_out(addr), .addr_oe_out(a_oe),
    .data_in(24'h5a3c96), .data_out(dout), .data_oe_out(d_oe), .strobe_out(strb),
    .strobe_oe_out(s_oe));

  ebg_master_model u_master (
    .core_clk_in(clk), .sys_rst_in(rst), .start_in(start), .hold_in(8'h04),
    .granted_out(granted), .lat_out(lat), .grant_n_in(gnt_n), .request_n_out(req_n));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic final_report();
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Bounded waits, so a dead handshake cannot hang the run
  task automatic wait_sig(input string nm, ref logic s, input logic v);
    int k;
    for (k = 0; k < 24 && s !== v; k++) @(negedge clk);
    chk(nm, {7'h0, v}, {7'h0, s});
  endtask

  task automatic request();
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      final_report();
    end
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    mem = '{addr: 14'h1abc, wdata: 24'h123456, wdrive: 1'b1, strobe: 7'h55};
    @(negedge clk);
    chk("rst_grant", 8'h01, {7'h0, gnt_n});
    chk("rst_drive", 8'h07, {5'h0, a_oe, d_oe, s_oe});
    chk("rst_core", 8'h01, {7'h0, rst_o});
    chk("rst_mode", 8'h00, {5'h0, mmode});
    chk("pass_addr", 8'hbc, addr[7:0]);
    chk("pass_data", 8'h56, dout[7:0]);
    chk("pass_strobe", 8'h55, {1'b0, strb});
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    foreach (ROWS[i]) begin
      @(posedge clk) core <= '{ROWS[i].rdy, ROWS[i].xreq, 1'b0, ROWS[i].go};
      request();
      wait_sig("granted", granted, 1'b1);
      chk("latency", 8'h03, lat);
      chk("grant", 8'h00, {7'h0, gnt_n});
      chk("drive", 8'h00, {5'h0, a_oe, d_oe, s_oe});
      chk("hang", {7'h0, ROWS[i].hang_n}, {7'h0, hang_n});
      if (ROWS[i].chk) chk("halt", {7'h0, ROWS[i].halt}, {7'h0, halt});
      chk("stall", {7'h0, ROWS[i].xreq}, {7'h0, stall});
      wait_sig("release", gnt_n, 1'b1);
      chk("redrive", 8'h07, {5'h0, a_oe, d_oe, s_oe});
      chk("unhang", 8'h07, {5'h0, hang_n, ~halt, ~stall});
    end
    chk("rdata", 8'h96, rdat[7:0]);
    // Access in flight holds the grant back
    @(posedge clk) core <= '{1'b1, 1'b1, 1'b1, 1'b0};
    request();
    repeat (8) @(negedge clk);
    chk("busy_hold", 8'h0e, {4'h0, gnt_n, a_oe, s_oe, req_n});
    @(posedge clk) core.ext_busy <= 1'b0;
    wait_sig("late_grant", gnt_n, 1'b0);
    wait_sig("late_rel", gnt_n, 1'b1);
    // Handshake while the processor is held in reset
    @(posedge clk) prst_n <= 1'b0;
    mode <= 3'h5;
    request();
    wait_sig("granted_rst", granted, 1'b1);
    chk("lat_rst", 8'h03, lat);
    chk("core_rst", 8'h01, {7'h0, rst_o});
    wait_sig("rel_rst", gnt_n, 1'b1);
    @(posedge clk) prst_n <= 1'b1;
    mode <= 3'h2;
    repeat (3) @(negedge clk);
    chk("mode_kept", 8'h05, {5'h0, mmode});
    // Emulator takes the pins and resets the chip
    @(posedge clk) etake <= 1'b1;
    erst_n <= 1'b0;
    mode <= 3'h6;
    repeat (3) @(negedge clk);
    chk("oe_off", 8'h01, {6'h0, gnt_oe, rst_o});
    @(posedge clk) erst_n <= 1'b1;
    mode <= 3'h1;
    repeat (3) @(negedge clk);
    chk("emu_mode", 8'h06, {4'h0, rst_o, mmode});
    @(posedge clk) ereq_n <= 1'b0;
    repeat (2) @(negedge clk);
    chk("emu_early", 8'h01, {7'h0, egnt_n});
    @(negedge clk) chk("emu_grant", 8'h01, {6'h0, egnt_n, gnt_n});
    chk("emu_drive", 8'h00, {6'h0, a_oe, s_oe});
    @(posedge clk) ereq_n <= 1'b1;
    repeat (3) @(negedge clk);
    chk("emu_rel", 8'h07, {5'h0, egnt_n, a_oe, s_oe});
    final_report();
  end
endmodule
